// file: hdl/gpio_led_pin_config.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module gpio_led_pin_config (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   input wire logic [2:0] gpio_in,
   output logic [2:0] gpio_out,
   output logic [2:0] gpio_oe,
   input wire logic [2:0] led_drive,
   input wire logic rom_data_in,
   output logic rom_data_out,
   output logic rom_data_oe,
   input wire logic rom_clock_in,
   output logic rom_clock_out,
   output logic rom_clock_oe,
   input wire logic rom_ctrl_clock,
   input wire logic rom_ctrl_data_out,
   input wire logic rom_ctrl_data_oe,
   output logic rom_ctrl_data_in,
   input wire logic tx_en,
   input wire logic tx_clk,
   output logic rx_dv_mon,
   output logic rx_clk_mon
);
   pin_sample_if pins ();

   logic [31:0] cfg, next_cfg;
   logic [2:0] status, next_status;
   logic [2:0] enable, next_enable;
   logic irq_q, next_irq;
   logic pending_any;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr, ar_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid_q, next_bvalid;
   logic [1:0] bresp_q, next_bresp;
   logic rvalid_q, next_rvalid;
   logic [1:0] rresp_q, next_rresp;
   logic [31:0] rdata_q, next_rdata;
   logic do_write;
   logic [2:0] led_sel, pol, drv_pp, dir, level_out;
   logic [1:0] gpo;
   gpio_led_pkg::rom_sel_t rom_sel;
   logic [2:0] next_gpio_out, next_gpio_oe;
   logic next_rom_data_out, next_rom_data_oe;
   logic next_rom_clock_out, next_rom_clock_oe;
   logic next_ctrl_in, next_rx_dv, next_rx_clk;
   logic ctrl_in_q, rx_dv_q, rx_clk_q;

   // byte-lane merge, shared by every writable register
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) res[b*8 +: 8] = data[b*8 +: 8];
      end
      return res;
   endfunction

   pin_input_filter #(
      .QUAL(gpio_led_pkg::QUAL_CYCLES)
   ) filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(pins.filt)
   );

   // field views of the configuration word
   always_comb begin
      led_sel = cfg[gpio_led_pkg::LED_LSB +: 3];
      pol = cfg[gpio_led_pkg::POL_LSB +: 3];
      rom_sel = gpio_led_pkg::rom_sel_t'(cfg[gpio_led_pkg::ROM_SEL_LSB +: 3]);
      drv_pp = cfg[gpio_led_pkg::BUF_LSB +: 3];
      dir = cfg[gpio_led_pkg::DIR_LSB +: 3];
      gpo = cfg[gpio_led_pkg::GPO_LSB +: 2];
      level_out = cfg[gpio_led_pkg::LEVEL_LSB +: 3];
   end

   assign pins.raw_level = gpio_in;
   assign pins.raw_rom_data = rom_data_in;
   assign pins.raw_rom_clock = rom_clock_in;
   assign pins.pin_event_polarity = pol;

   // write channel: address and data taken in either order
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid_q;
      next_bresp = bresp_q;
      do_write = aw_held && w_held && !bvalid_q;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         if (aw_addr == gpio_led_pkg::CFG_OFFSET ||
             aw_addr == gpio_led_pkg::STATUS_OFFSET ||
             aw_addr == gpio_led_pkg::ENABLE_OFFSET) begin
            next_bresp = gpio_led_pkg::RESP_OKAY;
         end else begin
            next_bresp = gpio_led_pkg::RESP_SLVERR;
         end
      end else if (bvalid_q && bready) begin
         next_bvalid = 1'b0;
      end
   end

   assign awready = !aw_held && !bvalid_q;
   assign wready = !w_held && !bvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   // register contents; a pin event beats a same-cycle clear
   always_comb begin
      logic [31:0] wm;
      wm = merge(32'h0000_0000, w_data, w_strb);
      next_cfg = cfg;
      next_enable = enable;
      next_status = status;
      if (do_write && aw_addr == gpio_led_pkg::CFG_OFFSET) begin
         next_cfg = merge(cfg, w_data, w_strb) & gpio_led_pkg::CFG_WMASK;
      end
      if (do_write && aw_addr == gpio_led_pkg::ENABLE_OFFSET) begin
         next_enable = wm[2:0];
      end
      if (do_write && aw_addr == gpio_led_pkg::STATUS_OFFSET) begin
         next_status = status & ~wm[2:0];
      end
      next_status = next_status | pins.event_hit;
      pending_any = |(status & enable);
      next_irq = pending_any;
   end

   // read channel: one cycle from address to data
   always_comb begin
      next_rvalid = rvalid_q;
      next_rdata = rdata_q;
      next_rresp = rresp_q;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = gpio_led_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (araddr == gpio_led_pkg::CFG_OFFSET) begin
            next_rdata = cfg;
            // pin levels read back from the pins themselves
            next_rdata[gpio_led_pkg::LEVEL_LSB +: 3] = pins.level_sync;
         end else if (araddr == gpio_led_pkg::STATUS_OFFSET) begin
            next_rdata[2:0] = status;
         end else if (araddr == gpio_led_pkg::ENABLE_OFFSET) begin
            next_rdata[2:0] = enable;
         end else begin
            next_rresp = gpio_led_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && rready) begin
         next_rvalid = 1'b0;
      end
   end

   assign arready = !rvalid_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign irq = irq_q;
   assign ar_addr = araddr;

   // general-purpose pins: led, push-pull, open-drain or input
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (led_sel[i]) begin
            next_gpio_oe[i] = 1'b1;
            next_gpio_out[i] = led_drive[i];
         end else if (dir[i] && drv_pp[i]) begin
            next_gpio_oe[i] = 1'b1;
            next_gpio_out[i] = level_out[i];
         end else if (dir[i]) begin
            // open-drain only ever pulls low
            next_gpio_oe[i] = !level_out[i];
            next_gpio_out[i] = 1'b0;
         end else begin
            next_gpio_oe[i] = 1'b0;
            next_gpio_out[i] = 1'b0;
         end
      end
   end

   // serial-rom pin routing; reserved codes leave both pins floating
   always_comb begin
      next_rom_data_out = 1'b0;
      next_rom_data_oe = 1'b0;
      next_rom_clock_out = 1'b0;
      next_rom_clock_oe = 1'b0;
      next_ctrl_in = 1'b0;
      next_rx_dv = 1'b0;
      next_rx_clk = 1'b0;
      case (rom_sel)
         gpio_led_pkg::ROM_NATIVE: begin
            next_rom_data_out = rom_ctrl_data_out;
            next_rom_data_oe = rom_ctrl_data_oe;
            next_rom_clock_out = rom_ctrl_clock;
            next_rom_clock_oe = 1'b1;
            next_ctrl_in = pins.rom_data_sync;
         end
         gpio_led_pkg::ROM_GPO_BOTH: begin
            next_rom_data_out = gpo[0];
            next_rom_data_oe = 1'b1;
            next_rom_clock_out = gpo[1];
            next_rom_clock_oe = 1'b1;
         end
         gpio_led_pkg::ROM_GPO_RXDV: begin
            next_rom_data_out = gpo[0];
            next_rom_data_oe = 1'b1;
            next_rx_dv = pins.rom_clock_sync;
         end
         gpio_led_pkg::ROM_TXEN_GPO: begin
            next_rom_data_out = tx_en;
            next_rom_data_oe = 1'b1;
            next_rom_clock_out = gpo[1];
            next_rom_clock_oe = 1'b1;
         end
         gpio_led_pkg::ROM_TXEN_RXDV: begin
            next_rom_data_out = tx_en;
            next_rom_data_oe = 1'b1;
            next_rx_dv = pins.rom_clock_sync;
         end
         gpio_led_pkg::ROM_CLKS: begin
            // resampled, so only slow clocks pass faithfully
            next_rom_data_out = tx_clk;
            next_rom_data_oe = 1'b1;
            next_rx_clk = pins.rom_clock_sync;
         end
         default: begin
            next_rom_data_oe = 1'b0;
         end
      endcase
   end

   // register every group; reset leaves the gpio pins as inputs and the rom pins in ROM_NATIVE routing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= gpio_led_pkg::CFG_RESET;
         status <= gpio_led_pkg::PINS_RESET;
         enable <= gpio_led_pkg::PINS_RESET;
         irq_q <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= gpio_led_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= gpio_led_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         gpio_out <= 3'h0;
         gpio_oe <= 3'h0;
         rom_data_out <= 1'b0;
         rom_data_oe <= 1'b0;
         rom_clock_out <= 1'b0;
         rom_clock_oe <= 1'b0;
         ctrl_in_q <= 1'b0;
         rx_dv_q <= 1'b0;
         rx_clk_q <= 1'b0;
      end else begin
         cfg <= next_cfg;
         status <= next_status;
         enable <= next_enable;
         irq_q <= next_irq;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid_q <= next_bvalid;
         bresp_q <= next_bresp;
         rvalid_q <= next_rvalid;
         rresp_q <= next_rresp;
         rdata_q <= next_rdata;
         gpio_out <= next_gpio_out;
         gpio_oe <= next_gpio_oe;
         rom_data_out <= next_rom_data_out;
         rom_data_oe <= next_rom_data_oe;
         rom_clock_out <= next_rom_clock_out;
         rom_clock_oe <= next_rom_clock_oe;
         ctrl_in_q <= next_ctrl_in;
         rx_dv_q <= next_rx_dv;
         rx_clk_q <= next_rx_clk;
      end
   end

   assign rom_ctrl_data_in = ctrl_in_q;
   assign rx_dv_mon = rx_dv_q;
   assign rx_clk_mon = rx_clk_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence read_cfg;
      arvalid && arready && ar_addr == gpio_led_pkg::CFG_OFFSET;
   endsequence

   led_pin_drive_a: assert property (
      led_sel[0] && $stable(led_sel) |=>
         gpio_oe[0] && gpio_out[0] == $past(led_drive[0]))
      else $error("led pin not driven from led source");
   event_sets_status_a: assert property (
      pins.event_hit[1] |=> status[1])
      else $error("pin event did not set status");
   irq_gate_a: assert property (
      ##1 irq == $past(pending_any))
      else $error("interrupt does not follow enabled status");
   gpo_route_a: assert property (
      rom_sel == gpio_led_pkg::ROM_GPO_BOTH |=>
         rom_data_oe && rom_clock_oe &&
         rom_data_out == $past(gpo[0]) && rom_clock_out == $past(gpo[1]))
      else $error("output-only levels not on rom pins");
   open_drain_high_a: assert property (
      !led_sel[2] && dir[2] && !drv_pp[2] && level_out[2] |=> !gpio_oe[2])
      else $error("open-drain pin driven while high");
   input_pin_a: assert property (
      !led_sel[1] && !dir[1] |=> !gpio_oe[1])
      else $error("input pin is being driven");
   push_pull_level_a: assert property (
      !led_sel[0] && dir[0] && drv_pp[0] |=>
         gpio_oe[0] && gpio_out[0] == $past(level_out[0]))
      else $error("output pin level differs from written value");
   level_readback_a: assert property (
      read_cfg |=> rvalid && rdata[2:0] == $past(pins.level_sync))
      else $error("pin level read does not show pin state");
   reserved_float_a: assert property (
      rom_sel == gpio_led_pkg::ROM_RSVD_A |=> !rom_data_oe && !rom_clock_oe)
      else $error("reserved rom code drives a pin");
   reset_state_a: assert property (
      $rose(aresetn) |-> cfg == gpio_led_pkg::CFG_RESET && gpio_oe == 3'h0)
      else $error("configuration not cleared by reset");
   set_beats_clear_a: assert property (
      do_write && aw_addr == gpio_led_pkg::STATUS_OFFSET &&
         pins.event_hit[1] |=> status[1])
      else $error("status clear lost a pin event");
   write_answer_a: assert property (
      do_write |=> bvalid)
      else $error("write response missing");
   resp_hold_a: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
endmodule // gpio_led_pin_config

// file: hdl/pin_input_filter.sv
`timescale 1ns/100ps
module pin_input_filter #(
   parameter int QUAL = gpio_led_pkg::QUAL_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   pin_sample_if.filt pins
);
   localparam int CW = $clog2(QUAL + 1);
   localparam logic [CW-1:0] QUAL_C = CW'(QUAL);

   logic [4:0] sync1, sync2, next_sync1, next_sync2;
   logic [CW-1:0] count [3];
   logic [CW-1:0] next_count [3];
   logic [2:0] hit, next_hit;
   logic [2:0] active;
   logic [1:0] fill, next_fill;

   // two flops per pin input; only the second stage is looked at
   always_comb begin
      next_sync1 = {pins.raw_rom_clock, pins.raw_rom_data, pins.raw_level};
      next_sync2 = sync1;
      next_fill = {fill[0], 1'b1};
   end

   // a level counts only once held active for the whole qualify time
   always_comb begin
      // gated until real samples arrive: reset zeros would fake a low level
      active = (sync2[2:0] ~^ pins.pin_event_polarity) & {3{fill[1]}};
      for (int i = 0; i < 3; i++) begin
         if (!active[i]) begin
            next_count[i] = '0;
         end else if (count[i] == QUAL_C) begin
            next_count[i] = QUAL_C;
         end else begin
            next_count[i] = count[i] + CW'(1);
         end
         next_hit[i] = (next_count[i] == QUAL_C);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         hit <= 3'h0;
         fill <= 2'h0;
         for (int i = 0; i < 3; i++) count[i] <= '0;
      end else begin
         fill <= next_fill;
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         hit <= next_hit;
         for (int i = 0; i < 3; i++) count[i] <= next_count[i];
      end
   end

   assign pins.level_sync = sync2[2:0];
   assign pins.rom_data_sync = sync2[3];
   assign pins.rom_clock_sync = sync2[4];
   assign pins.event_hit = hit;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // a hit needs two consecutive active samples before it
   sequence held_active(int k);
      active[k] ##1 active[k];
   endsequence
   qualify_hold_a: assert property (
      $rose(hit[0]) |-> $past(active[0], 1) && $past(active[0], 2))
      else $error("pin event hit without qualified hold");
   hold_gives_hit_a: assert property (
      held_active(1) |=> hit[1])
      else $error("held active level gave no hit");
endmodule // pin_input_filter

// file: inc/gpio_led_pkg.sv
package gpio_led_pkg;
   // pin counts and register-bus address width
   localparam int PIN_COUNT = 3;
   localparam int GPO_COUNT = 2;
   localparam int ADDR_W = 8;

   // byte offsets on the register bus
   localparam logic [7:0] CFG_OFFSET = 8'h88;
   localparam logic [7:0] STATUS_OFFSET = 8'h58;
   localparam logic [7:0] ENABLE_OFFSET = 8'h5C;

   // field positions inside pin_function_config
   localparam int LED_LSB = 28;
   localparam int POL_LSB = 24;
   localparam int ROM_SEL_LSB = 20;
   localparam int BUF_LSB = 16;
   localparam int DIR_LSB = 8;
   localparam int GPO_LSB = 3;
   localparam int LEVEL_LSB = 0;

   // writable bits; reserved bits stay zero
   localparam logic [31:0] CFG_WMASK = 32'h7777_071F;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [2:0] PINS_RESET = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // input qualification time, rounded up to whole clocks
   localparam int CLK_PERIOD_NS = 20;
   localparam int QUAL_TIME_NS = 40;
   localparam int QUAL_RAW = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUAL_CYCLES = (QUAL_RAW < 1) ? 1 : QUAL_RAW;

   // serial-rom pin function select codes
   typedef enum logic [2:0] {
      ROM_NATIVE    = 3'h0,
      ROM_GPO_BOTH  = 3'h1,
      ROM_RSVD_A    = 3'h2,
      ROM_GPO_RXDV  = 3'h3,
      ROM_RSVD_B    = 3'h4,
      ROM_TXEN_GPO  = 3'h5,
      ROM_TXEN_RXDV = 3'h6,
      ROM_CLKS      = 3'h7
   } rom_sel_t;
endpackage

// file: inc/pin_sample_if.sv
`timescale 1ns/100ps
interface pin_sample_if;
   logic [2:0] raw_level;
   logic raw_rom_data;
   logic raw_rom_clock;
   logic [2:0] pin_event_polarity;
   logic [2:0] level_sync;
   logic rom_data_sync;
   logic rom_clock_sync;
   logic [2:0] event_hit;

   modport filt (
      input raw_level, raw_rom_data, raw_rom_clock, pin_event_polarity,
      output level_sync, rom_data_sync, rom_clock_sync, event_hit
   );
   modport core (
      output raw_level, raw_rom_data, raw_rom_clock, pin_event_polarity,
      input level_sync, rom_data_sync, rom_clock_sync, event_hit
   );
endinterface

// file: testbench/pin_partner.sv
`timescale 1ns/100ps
// far side of the pins: pull-ups, outside drivers, rom clock pin source
module pin_partner (
   input wire logic [2:0] gpio_out,
   input wire logic [2:0] gpio_oe,
   input wire logic [2:0] ext_en,
   input wire logic [2:0] ext_val,
   output logic [2:0] gpio_in,
   input wire logic rom_data_out,
   input wire logic rom_data_oe,
   input wire logic rom_clock_out,
   input wire logic rom_clock_oe,
   input wire logic ext_clock_val,
   output logic rom_data_in,
   output logic rom_clock_in
);
   // pin level from every driver; a released open-drain line floats high
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         gpio_in[i] = gpio_oe[i] ? gpio_out[i]
            : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
   // rom data line pulled up; clock line fed by the far-side signal source
   assign rom_data_in = rom_data_oe ? rom_data_out : 1'b1;
   assign rom_clock_in = rom_clock_oe ? rom_clock_out : ext_clock_val;
endmodule // pin_partner

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [2:0] gpio_in, gpio_out, gpio_oe, led_drive, ext_en, ext_val;
   logic rom_data_in, rom_data_out, rom_data_oe, rom_clock_in, rom_clock_out;
   logic rom_clock_oe, rom_ctrl_clock, rom_ctrl_data_out, rom_ctrl_data_oe;
   logic rom_ctrl_data_in, tx_en, tx_clk, rx_dv_mon, rx_clk_mon;
   logic ext_clock_val;
   logic [5:0] rom_exp [0:7];
   int err_total, cmp_count;

   gpio_led_pin_config DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .gpio_in,
      .gpio_out, .gpio_oe, .led_drive, .rom_data_in, .rom_data_out,
      .rom_data_oe, .rom_clock_in, .rom_clock_out, .rom_clock_oe,
      .rom_ctrl_clock, .rom_ctrl_data_out, .rom_ctrl_data_oe,
      .rom_ctrl_data_in, .tx_en, .tx_clk, .rx_dv_mon, .rx_clk_mon);
   pin_partner PART (.gpio_out, .gpio_oe, .ext_en, .ext_val, .gpio_in,
      .rom_data_out, .rom_data_oe, .rom_clock_out, .rom_clock_oe,
      .ext_clock_val, .rom_data_in, .rom_clock_in);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic test_done;
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      test_done;
   end

   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle count assumed: the watchdog ends a hung wait
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // register read compared on data and response
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er);
      rdreg(a, rd, rs);
      chk("rdata", e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rs});
   endtask

   // let pin updates and synchronisers settle, then sample off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   initial begin
      rom_exp = '{6'h0B, 6'h0E, 6'h00, 6'h2C, 6'h00, 6'h0A, 6'h28, 6'h1C};
      err_total = 0;
      cmp_count = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      {led_drive, ext_en, ext_val} = 9'h000;
      {rom_ctrl_clock, rom_ctrl_data_out, rom_ctrl_data_oe} = 3'h5;
      {tx_en, tx_clk, ext_clock_val} = 3'h3;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      tick(3);
      chk("gpio_oe", 32'h0, {29'h0, gpio_oe});
      chk("rom_clock_oe", 32'h1, {31'h0, rom_clock_oe});
      // controller lets go of the data pin: its pull-up reads back
      @(posedge aclk);
      rom_ctrl_data_oe <= 1'b0;
      tick(5);
      chk("ctrl_data_in", 32'h1, {31'h0, rom_ctrl_data_in});
      @(posedge aclk);
      rom_ctrl_data_oe <= 1'b1;
      rdchk(gpio_led_pkg::CFG_OFFSET, 32'h7, 2'h0);
      rdchk(gpio_led_pkg::STATUS_OFFSET, 32'h0, 2'h0);
      rdchk(8'h40, 32'h0, gpio_led_pkg::RESP_SLVERR);
      wr(8'h40, 32'hFFFF_FFFF, 4'hF, rs);
      chk("bresp", {30'h0, gpio_led_pkg::RESP_SLVERR}, {30'h0, rs});
      // only reserved bits written: nothing may stick
      wr(gpio_led_pkg::CFG_OFFSET, 32'h8888_F8E0, 4'hF, rs);
      rdchk(gpio_led_pkg::CFG_OFFSET, 32'h7, 2'h0);
      // pin 1 held low for many cycles, masked, then unmasked
      ext_en <= 3'h2;
      tick(8);
      rdchk(gpio_led_pkg::STATUS_OFFSET, 32'h2, 2'h0);
      chk("irq", 32'h0, {31'h0, irq});
      wr(gpio_led_pkg::ENABLE_OFFSET, 32'h2, 4'hF, rs);
      tick(2);
      chk("irq", 32'h1, {31'h0, irq});
      ext_val <= 3'h2;
      tick(8);
      wr(gpio_led_pkg::STATUS_OFFSET, 32'h7, 4'hF, rs);
      tick(2);
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(gpio_led_pkg::STATUS_OFFSET, 32'h0, 2'h0);
      // high level now active for pin 1
      wr(gpio_led_pkg::CFG_OFFSET, 32'h0200_0000, 4'hF, rs);
      tick(8);
      rdchk(gpio_led_pkg::STATUS_OFFSET, 32'h2, 2'h0);
      chk("irq", 32'h1, {31'h0, irq});
      // pin still active: the clear loses to the level
      wr(gpio_led_pkg::STATUS_OFFSET, 32'h2, 4'hF, rs);
      rdchk(gpio_led_pkg::STATUS_OFFSET, 32'h2, 2'h0);
      ext_en <= 3'h0;
      wr(gpio_led_pkg::ENABLE_OFFSET, 32'h0, 4'hF, rs);
      // push-pull outputs drive the written levels
      wr(gpio_led_pkg::CFG_OFFSET, 32'h0007_0705, 4'hF, rs);
      tick(3);
      chk("gpio_oe", 32'h7, {29'h0, gpio_oe});
      chk("gpio_out", 32'h5, {29'h0, gpio_out});
      rdchk(gpio_led_pkg::CFG_OFFSET, 32'h0007_0705, 2'h0);
      // open drain only pulls low; pin 0 is then forced low from outside
      wr(gpio_led_pkg::CFG_OFFSET, 32'h0000_0705, 4'hF, rs);
      ext_en <= 3'h1;
      ext_val <= 3'h0;
      tick(4);
      chk("gpio_oe", 32'h2, {29'h0, gpio_oe});
      chk("gpio_out", 32'h0, {29'h0, gpio_out});
      rdchk(gpio_led_pkg::CFG_OFFSET, 32'h0000_0704, 2'h0);
      ext_en <= 3'h0;
      // top byte only: led mode on all pins, lower fields kept
      led_drive <= 3'h6;
      wr(gpio_led_pkg::CFG_OFFSET, 32'h7000_0000, 4'h8, rs);
      tick(3);
      chk("gpio_oe", 32'h7, {29'h0, gpio_oe});
      chk("gpio_out", 32'h6, {29'h0, gpio_out});
      rdchk(gpio_led_pkg::CFG_OFFSET, 32'h7000_0706, 2'h0);
      // every rom select code, reserved ones too; no rom cycle is running
      for (int c = 0; c < 8; c++) begin
         wr(gpio_led_pkg::CFG_OFFSET, (32'(c) << 20) | 32'h8, 4'hF, rs);
         tick(5);
         chk("rom pins", {26'h0, rom_exp[c]}, {26'h0, rx_dv_mon, rx_clk_mon,
            rom_data_oe, rom_data_oe & rom_data_out, rom_clock_oe,
            rom_clock_oe & rom_clock_out});
      end
      test_done;
   end
endmodule // tb
